// ===== src/acquisition_polarity_config.sv
// acquisition polarity configuration and result coding with Wishbone slave
// Functional notes
// - one bipolar select bit per cell
// - unipolar 0..5V maps 0000h..3FFFh
// - bipolar -2.5..2.5V maps 0000h..3FFFh
// - result code in bits 15:2
// - diagnostics force polarity over select bits
// - six aux reference bits, unipolar scaling
// - comparator skips bipolar cells
// - threshold code left aligned, FFC0h max
// - acquisition type selects eight operations
// - sample interval for converter/comparator types
// - diag type write sets switches immediately
// - reset clears all bipolar bits
// - bipolar faults masked in switch diagnostics
// - option bit includes bipolar in extremes
// - bipolar cells use bipolar limits
// - no comparator alerts for bipolar cells
// - trigger self clears, done flag sets
// - type writes ignored while done set
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module acquisition_polarity_config (
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [7:0]                        wb_adr_i,
	input  wire logic [3:0]                        wb_sel_i,
	input  wire logic [31:0]                       wb_dat_i,
	output logic      [31:0]                       wb_dat_o,
	output logic                                   wb_ack_o,
	// converter side: cell under conversion and its raw code
	input  wire logic                              conv_valid_i,
	input  wire logic [3:0]                        conv_cell_i,
	input  wire logic [acq_cfg_pkg::ADC_BITS-1:0]  conv_code_i,
	input  wire logic                              diag_force_i,
	input  wire logic                              diag_force_bipolar_i,
	input  wire logic                              cmp_valid_i,
	input  wire logic [3:0]                        cmp_cell_i,
	input  wire logic [acq_cfg_pkg::CMP_BITS-1:0]  cmp_code_i,
	input  wire logic                              balsw_fault_i,
	input  wire logic                              acq_complete_i,
	output logic      [15:0]                       cell_result_o,
	output logic                                   cell_result_valid_o,
	output logic                                   conv_bipolar_o,
	output logic      [acq_cfg_pkg::NUM_AUX-1:0]   aux_reference_sel_o,
	output logic                                   cmp_skip_o,
	output logic                                   overvoltage_alert_o,
	output logic                                   undervoltage_alert_o,
	output logic                                   comparator_overvoltage_alert_o,
	output logic                                   comparator_undervoltage_alert_o,
	output logic                                   extreme_candidate_o,
	output logic                                   balsw_fault_o,
	output logic      [2:0]                        acquisition_type_sel_o,
	output logic      [2:0]                        balance_switch_diag_o,
	output logic                                   interval_enable_o,
	output logic      [3:0]                        sample_interval_sel_o,
	output logic      [2:0]                        oversample_count_o,
	output logic                                   acq_busy_o
);
	import acq_cfg_pkg::*;

	logic [13:0]  cell_bipolar_ctrl_reg;
	logic [5:0]   aux_reference_ctrl_reg;
	acq_type_t    acq_type_reg;
	logic [3:0]   interval_reg;
	logic [2:0]   ovs_reg;
	logic         done_reg;
	logic         extremes_include_bipolar;
	logic [15:0]  bip_ov_reg;
	logic [15:0]  bip_uv_reg;
	logic [15:0]  cell_ov_reg;
	logic [15:0]  cell_uv_reg;
	logic [15:0]  cmp_hi_reg;
	logic [15:0]  cmp_lo_reg;
	logic [13:0]  bipolar_latch_reg;
	logic [5:0]   aux_latch_reg;
	acq_state_t   state_reg;
	logic [7:0]   run_cnt_reg;

	wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire bus_wr    = bus_req && wb_we_i;
	wire wr_lo     = bus_wr && wb_sel_i[0];
	wire wr_hi     = bus_wr && wb_sel_i[1];
	wire sel_bip   = (wb_adr_i == ADDR_BIPOLAR);
	wire sel_aux   = (wb_adr_i == ADDR_AUXREF);
	wire sel_ctl   = (wb_adr_i == ADDR_ACQCTRL);
	wire sel_opt   = (wb_adr_i == ADDR_OPTIONS);
	wire trig_wr   = wr_lo && sel_ctl && wb_dat_i[ACQ_TRIGGER_BIT];
	// done bit is write-one-to-clear
	wire done_clr  = wr_lo && sel_ctl && wb_dat_i[ACQ_DONE_BIT];
	wire type_wr   = wr_lo && sel_ctl && !done_reg;
	wire acq_start = trig_wr && (state_reg == ST_IDLE);
	wire acq_end   = (state_reg == ST_RUN) && (acq_complete_i || run_cnt_reg == 8'h00);
	wire busy      = (state_reg == ST_RUN);

	// per-cell latched polarity view for the running acquisition
	wire [13:0] bip_view = busy ? bipolar_latch_reg : cell_bipolar_ctrl_reg;
	wire [5:0]  aux_view = busy ? aux_latch_reg : aux_reference_ctrl_reg;
	wire        cell_in  = (conv_cell_i < 4'(NUM_CELLS));
	wire        cell_bip = cell_in && bip_view[conv_cell_i];
	// diagnostic polarity overrides the select bit
	wire        eff_bip  = diag_force_i ? diag_force_bipolar_i : cell_bip;
	// 14-bit code carries scaling for both ranges; mid-scale is zero for bipolar
	wire [15:0] result_w = {conv_code_i, ADC_PAD};
	wire        cmp_in   = (cmp_cell_i < 4'(NUM_CELLS));
	wire        cmp_bip  = cmp_in && bip_view[cmp_cell_i];
	wire        cmp_run  = (acq_type_reg == ACQ_ADC_CMP) || (acq_type_reg == ACQ_CMP);
	wire        cmp_skip = cmp_valid_i && cmp_bip;
	wire [15:0] cmp_word = {cmp_code_i, CMP_PAD};
	wire [15:0] ov_lim   = cell_bip ? bip_ov_reg : cell_ov_reg;
	wire [15:0] uv_lim   = cell_bip ? bip_uv_reg : cell_uv_reg;
	wire        ov_hit   = conv_valid_i && cell_in && (result_w > ov_lim);
	wire        uv_hit   = conv_valid_i && cell_in && (result_w < uv_lim);
	wire        cmp_ov   = cmp_valid_i && cmp_run && !cmp_bip && (cmp_word > cmp_hi_reg);
	wire        cmp_uv   = cmp_valid_i && cmp_run && !cmp_bip && (cmp_word < cmp_lo_reg);
	wire        extreme  = conv_valid_i && cell_in && (!cell_bip || extremes_include_bipolar);
	wire        diag_typ = acq_type_reg[2];
	wire        bal_fault = balsw_fault_i && diag_typ && conv_valid_i && !cell_bip;
	// free-run when interval field is zero, host then paces scans
	wire        interval_en = (acq_type_reg <= ACQ_CMP) && (interval_reg != 4'h0);

	wire [31:0] ctl_rd = {16'h0000, 1'b0, ovs_reg, interval_reg, 1'b0, acq_type_reg,
		2'b00, done_reg, 1'b0};
	wire [31:0] sts_rd = {30'h00000000, busy, done_reg};
	logic [31:0] rd_mux;
	always_comb begin
		if (sel_bip) begin
			rd_mux = {18'h00000, cell_bipolar_ctrl_reg};
		end else if (sel_aux) begin
			rd_mux = {26'h0000000, aux_reference_ctrl_reg};
		end else if (sel_ctl) begin
			rd_mux = ctl_rd; // trigger reads zero
		end else if (sel_opt) begin
			rd_mux = {31'h00000000, extremes_include_bipolar};
		end else if (wb_adr_i == ADDR_BIP_OV) begin
			rd_mux = {16'h0000, bip_ov_reg};
		end else if (wb_adr_i == ADDR_BIP_UV) begin
			rd_mux = {16'h0000, bip_uv_reg};
		end else if (wb_adr_i == ADDR_CELL_OV) begin
			rd_mux = {16'h0000, cell_ov_reg};
		end else if (wb_adr_i == ADDR_CELL_UV) begin
			rd_mux = {16'h0000, cell_uv_reg};
		end else if (wb_adr_i == ADDR_CMP_HI) begin
			rd_mux = {16'h0000, cmp_hi_reg};
		end else if (wb_adr_i == ADDR_CMP_LO) begin
			rd_mux = {16'h0000, cmp_lo_reg};
		end else if (wb_adr_i == ADDR_STATUS) begin
			rd_mux = sts_rd;
		end else if (wb_adr_i == ADDR_LATCHED) begin
			rd_mux = {10'h000, aux_latch_reg, 2'b00, bipolar_latch_reg};
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
		end
	end

	// 16-bit thresholds with byte lanes
	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
		input logic lo, input logic hi);
		lane16 = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
	endfunction : lane16

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cell_bipolar_ctrl_reg    <= BIPOLAR_RST;
			aux_reference_ctrl_reg   <= AUXREF_RST;
			extremes_include_bipolar <= 1'b0;
			bip_ov_reg  <= LIMIT_RST;
			bip_uv_reg  <= LIMIT_RST;
			cell_ov_reg <= LIMIT_RST;
			cell_uv_reg <= LIMIT_RST;
			cmp_hi_reg  <= LIMIT_RST;
			cmp_lo_reg  <= LIMIT_RST;
		end else begin
			if (sel_bip) begin
				cell_bipolar_ctrl_reg <= 14'(lane16({2'b00, cell_bipolar_ctrl_reg}, wb_dat_i,
					wr_lo, wr_hi));
			end
			if (sel_aux && wr_lo) begin
				aux_reference_ctrl_reg <= wb_dat_i[5:0];
			end
			if (sel_opt && wr_lo) begin
				extremes_include_bipolar <= wb_dat_i[OPT_EXTREMES_BIT];
			end
			if (wb_adr_i == ADDR_BIP_OV) bip_ov_reg <= lane16(bip_ov_reg, wb_dat_i, wr_lo, wr_hi);
			if (wb_adr_i == ADDR_BIP_UV) bip_uv_reg <= lane16(bip_uv_reg, wb_dat_i, wr_lo, wr_hi);
			if (wb_adr_i == ADDR_CELL_OV) cell_ov_reg <= lane16(cell_ov_reg, wb_dat_i, wr_lo, wr_hi);
			if (wb_adr_i == ADDR_CELL_UV) cell_uv_reg <= lane16(cell_uv_reg, wb_dat_i, wr_lo, wr_hi);
			// low six bits of comparator limits are not stored
			if (wb_adr_i == ADDR_CMP_HI) cmp_hi_reg <= lane16(cmp_hi_reg, wb_dat_i, wr_lo, wr_hi)
				& 16'hFFC0;
			if (wb_adr_i == ADDR_CMP_LO) cmp_lo_reg <= lane16(cmp_lo_reg, wb_dat_i, wr_lo, wr_hi)
				& 16'hFFC0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acq_type_reg <= ACQ_ADC;
			interval_reg <= 4'h0;
			ovs_reg      <= 3'h0;
		end else if (type_wr) begin
			acq_type_reg <= acq_type_t'(wb_dat_i[ACQ_TYPE_LSB +: 3]);
			interval_reg <= wb_dat_i[ACQ_INTERVAL_LSB +: 4];
			ovs_reg      <= wb_dat_i[ACQ_OVS_LSB +: 3];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg         <= ST_IDLE;
			run_cnt_reg       <= 8'h00;
			done_reg          <= 1'b0;
			bipolar_latch_reg <= BIPOLAR_RST;
			aux_latch_reg     <= AUXREF_RST;
		end else begin
			// completion wins over a same-cycle clear
			if (acq_end) begin
				done_reg <= 1'b1;
			end else if (done_clr) begin
				done_reg <= 1'b0;
			end
			case (state_reg)
				ST_IDLE: begin
					if (acq_start) begin
						state_reg         <= ST_RUN;
						run_cnt_reg       <= ACQ_RUN_CYCLES;
						bipolar_latch_reg <= cell_bipolar_ctrl_reg;
						aux_latch_reg     <= aux_reference_ctrl_reg;
					end
				end
				ST_RUN: begin
					run_cnt_reg <= run_cnt_reg - 8'h01;
					if (acq_end) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cell_result_o                   <= 16'h0000;
			cell_result_valid_o             <= 1'b0;
			conv_bipolar_o                  <= 1'b0;
			aux_reference_sel_o             <= AUXREF_RST;
			cmp_skip_o                      <= 1'b0;
			overvoltage_alert_o             <= 1'b0;
			undervoltage_alert_o            <= 1'b0;
			comparator_overvoltage_alert_o  <= 1'b0;
			comparator_undervoltage_alert_o <= 1'b0;
			extreme_candidate_o             <= 1'b0;
			balsw_fault_o                   <= 1'b0;
			acquisition_type_sel_o          <= ACQ_ADC;
			balance_switch_diag_o           <= 3'h0;
			interval_enable_o               <= 1'b0;
			sample_interval_sel_o           <= 4'h0;
			oversample_count_o              <= 3'h0;
			acq_busy_o                      <= 1'b0;
		end else begin
			cell_result_o                   <= conv_valid_i ? result_w : cell_result_o;
			cell_result_valid_o             <= conv_valid_i;
			conv_bipolar_o                  <= eff_bip;
			aux_reference_sel_o             <= aux_view;
			cmp_skip_o                      <= cmp_skip;
			overvoltage_alert_o             <= ov_hit;
			undervoltage_alert_o            <= uv_hit;
			comparator_overvoltage_alert_o  <= cmp_ov;
			comparator_undervoltage_alert_o <= cmp_uv;
			extreme_candidate_o             <= extreme;
			balsw_fault_o                   <= bal_fault;
			acquisition_type_sel_o          <= acq_type_reg;
			// switches follow the register, not the trigger
			balance_switch_diag_o           <= diag_typ ? acq_type_reg : 3'h0;
			interval_enable_o               <= interval_en;
			sample_interval_sel_o           <= interval_reg;
			oversample_count_o              <= ovs_reg;
			acq_busy_o                      <= busy;
		end
	end

	wb_ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	trig_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !wb_we_i && $past(sel_ctl) |-> !wb_dat_o[ACQ_TRIGGER_BIT])
		else $error("trigger read back one");
	done_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
		acq_end |=> done_reg) else $error("done not set");
	type_blocked_a: assert property (@(posedge clk_i) disable iff (rst_i)
		done_reg && !acq_end |=> $stable(acq_type_reg)) else $error("type changed while done");
	latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		busy && $past(busy) |-> $stable(bipolar_latch_reg)) else $error("latch moved");
	cmp_bip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmp_valid_i && cmp_bip |=> !comparator_overvoltage_alert_o &&
		!comparator_undervoltage_alert_o && cmp_skip_o) else $error("bipolar comparator alert");
	result_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_valid_i |=> cell_result_o == {$past(conv_code_i), 2'b00}) else $error("bad code");
	switch_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
		type_wr && wb_dat_i[ACQ_TYPE_LSB + 2] |=> ##1 balance_switch_diag_o != 3'h0)
		else $error("switches late");
	balsw_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cell_bip && !diag_force_i |=> !balsw_fault_o) else $error("bipolar fault shown");

	// two steps: trigger taken, then the run shows a cycle later
	sequence acq_launch_s;
		acq_start ##1 busy;
	endsequence
	launch_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		acq_launch_s |-> bipolar_latch_reg == $past(cell_bipolar_ctrl_reg) &&
		aux_latch_reg == $past(aux_reference_ctrl_reg)) else $error("selections not captured");
	reset_clear_a: assert property (@(posedge clk_i)
		rst_i |=> cell_bipolar_ctrl_reg == BIPOLAR_RST)
		else $error("bipolar bits not cleared");
	done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		done_clr && !acq_end |=> !done_reg)
		else $error("done not cleared");
	bip_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_valid_i && cell_bip && (result_w > bip_ov_reg) |=> overvoltage_alert_o)
		else $error("bipolar limit ignored");
	extreme_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_valid_i && cell_bip && !extremes_include_bipolar |=> !extreme_candidate_o)
		else $error("bipolar cell in extremes");
	interval_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		interval_reg == 4'h0 |=> !interval_enable_o)
		else $error("interval enabled while unset");
	aux_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		busy |=> aux_reference_sel_o == $past(aux_latch_reg))
		else $error("aux selection not latched");
endmodule : acquisition_polarity_config

// ===== src/acq_cfg_pkg.sv
// shared constants for the acquisition polarity and configuration block
package acq_cfg_pkg;
	localparam int NUM_CELLS = 14;
	localparam int NUM_AUX   = 6;
	// register byte addresses
	localparam logic [7:0] ADDR_BIPOLAR   = 8'h00;
	localparam logic [7:0] ADDR_AUXREF    = 8'h04;
	localparam logic [7:0] ADDR_ACQCTRL   = 8'h08;
	localparam logic [7:0] ADDR_OPTIONS   = 8'h0C;
	localparam logic [7:0] ADDR_BIP_OV    = 8'h10;
	localparam logic [7:0] ADDR_BIP_UV    = 8'h14;
	localparam logic [7:0] ADDR_CELL_OV   = 8'h18;
	localparam logic [7:0] ADDR_CELL_UV   = 8'h1C;
	localparam logic [7:0] ADDR_CMP_HI    = 8'h20;
	localparam logic [7:0] ADDR_CMP_LO    = 8'h24;
	localparam logic [7:0] ADDR_STATUS    = 8'h28;
	localparam logic [7:0] ADDR_LATCHED   = 8'h2C;
	// acquisition control fields
	localparam int ACQ_TRIGGER_BIT = 0;
	localparam int ACQ_DONE_BIT    = 1;
	localparam int ACQ_TYPE_LSB    = 4;
	localparam int ACQ_INTERVAL_LSB = 8;
	localparam int ACQ_OVS_LSB     = 12;
	localparam int OPT_EXTREMES_BIT = 0;
	// reset values
	localparam logic [13:0] BIPOLAR_RST = 14'h0000;
	localparam logic [5:0]  AUXREF_RST  = 6'h00;
	localparam logic [15:0] LIMIT_RST   = 16'h0000;
	// code layout
	localparam int ADC_BITS = 14;
	localparam int CMP_BITS = 10;
	localparam logic [1:0] ADC_PAD = 2'h0;
	localparam logic [5:0] CMP_PAD = 6'h00;
	// acquisition run time in cycles (stand-in for the sequencer)
	localparam logic [7:0] ACQ_RUN_CYCLES = 8'h10;
	typedef enum logic [2:0] {
		ACQ_ADC       = 3'h0,
		ACQ_ADC_CMP   = 3'h1,
		ACQ_CMP       = 3'h2,
		ACQ_CAL       = 3'h3,
		ACQ_BAL_SHORT = 3'h4,
		ACQ_BAL_OPEN  = 3'h5,
		ACQ_ODD_OPEN  = 3'h6,
		ACQ_EVEN_OPEN = 3'h7
	} acq_type_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11
	} acq_state_t;
endpackage : acq_cfg_pkg

// ===== sim/test_acquisition_polarity_config.sv
// self-checking bench for the acquisition polarity configuration block
`timescale 1ns/1ps
module test_acquisition_polarity_config;
	import acq_cfg_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, we = 1'b0, cv = 1'b0, df = 1'b0, dfb = 1'b0;
	logic        kv = 1'b0, bf = 1'b0, ac = 1'b0, b;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, ctl;
	logic [3:0]  cc = 4'h0, kc = 4'h0, int_o;
	logic [13:0] code = 14'h0, bip, val;
	logic [9:0]  kcode = 10'h0;
	logic [5:0]  ax, aux_o;
	logic [15:0] r, res_o;
	logic [31:0] dat_o;
	logic [2:0]  typ_o, diag_o, ovs_o;
	logic        ack_o, resv_o, bip_o, skip_o, ov_o, uv_o, cov_o, cuv_o, ext_o, bsf_o, ien_o;
	logic        busy_o;
	int          n_fail = 0, tests_run = 0, cyc_cnt = 0;
	logic [32:0] rq[$];
	logic [16:0] cq[$];

	acquisition_polarity_config dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
		.conv_valid_i(cv), .conv_cell_i(cc), .conv_code_i(code), .diag_force_i(df),
		.diag_force_bipolar_i(dfb), .cmp_valid_i(kv), .cmp_cell_i(kc), .cmp_code_i(kcode),
		.balsw_fault_i(bf), .acq_complete_i(ac), .cell_result_o(res_o),
		.cell_result_valid_o(resv_o), .conv_bipolar_o(bip_o), .aux_reference_sel_o(aux_o),
		.cmp_skip_o(skip_o), .overvoltage_alert_o(ov_o), .undervoltage_alert_o(uv_o),
		.comparator_overvoltage_alert_o(cov_o), .comparator_undervoltage_alert_o(cuv_o),
		.extreme_candidate_o(ext_o), .balsw_fault_o(bsf_o), .acquisition_type_sel_o(typ_o),
		.balance_switch_diag_o(diag_o), .interval_enable_o(ien_o),
		.sample_interval_sel_o(int_o), .oversample_count_o(ovs_o), .acq_busy_o(busy_o)
	);

	always #2 clk_i = ~clk_i;

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// one classic cycle; the expected read data waits in the queue for the monitor
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] e);
		int n;
		n = 0;
		rq.push_back({~w, e});
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk(32'h0, 32'h1);
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 32'h0);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, e);
	endtask : rdc

	task automatic conv(input logic [3:0] c, input logic [13:0] k, input logic f,
			input logic fb);
		cq.push_back({f ? fb : bip[c], k, 2'b00});
		@(posedge clk_i);
		cv <= 1'b1;
		cc <= c;
		code <= k;
		df <= f;
		dfb <= fb;
		@(posedge clk_i);
		cv <= 1'b0;
		df <= 1'b0;
		@(posedge clk_i);
	endtask : conv

	task automatic kcmp(input logic [3:0] c, input logic [9:0] k);
		@(posedge clk_i);
		kv <= 1'b1;
		kc <= c;
		kcode <= k;
		@(posedge clk_i);
		kv <= 1'b0;
		@(posedge clk_i);
	endtask : kcmp

	// early end comes from the sequencer pulse instead of the run timer
	task automatic fin(input logic early);
		int n;
		n = 0;
		if (early) begin
			@(posedge clk_i);
			ac <= 1'b1;
			@(posedge clk_i);
			ac <= 1'b0;
		end
		do begin
			@(posedge clk_i);
			n++;
		end while (busy_o !== 1'b0 && n < 40);
		chk(n < (early ? 8 : 40), 1'b1);
		rdc(ADDR_STATUS, 32'h1);
		rdc(ADDR_ACQCTRL, ctl | 32'h2);
		wr(ADDR_ACQCTRL, ctl ^ 32'h70);
		rdc(ADDR_ACQCTRL, ctl | 32'h2);
		wr(ADDR_ACQCTRL, ctl | 32'h2);
		rdc(ADDR_STATUS, 32'h0);
	endtask : fin

	task automatic acq(input logic early);
		wr(ADDR_ACQCTRL, ctl | 32'h1);
		fin(early);
	endtask : acq

	always @(posedge clk_i) begin : mon
		logic [32:0] e;
		if (!rst_i && ack_o === 1'b1) begin
			if (rq.size() == 0)
				chk(32'h0, 32'h1);
			else begin
				e = rq.pop_front();
				if (e[32])
					chk(dat_o, e[31:0]);
			end
		end
		if (!rst_i && resv_o === 1'b1) begin
			if (cq.size() == 0)
				chk(32'h0, 32'h1);
			else
				chk({bip_o, res_o}, cq.pop_front());
		end
	end

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial begin
		void'($urandom(32'hD4FFA6A5));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(ADDR_BIPOLAR, 32'h0);
		rdc(ADDR_AUXREF, 32'h0);
		rdc(ADDR_ACQCTRL, 32'h0);
		wr(8'h30, 32'hFFFF);
		rdc(8'h30, 32'h0);
		for (int t = 0; t < 8; t++) begin
			ctl = 32'h5300 | (t << 4);
			wr(ADDR_ACQCTRL, ctl);
			// outputs follow the register one cycle after the ack edge
			@(negedge clk_i);
			chk(typ_o, t);
			chk(diag_o, t >= 4 ? t : 0);
			chk(ien_o, t <= 2);
			chk({ovs_o, int_o}, 32'h53);
			rdc(ADDR_ACQCTRL, ctl);
		end
		wr(ADDR_CMP_HI, 32'hFFFF);
		rdc(ADDR_CMP_HI, 32'hFFC0);
		wr(ADDR_CMP_HI, 32'h8000);
		wr(ADDR_CMP_LO, 32'h4000);
		wr(ADDR_CELL_OV, 32'hC000);
		wr(ADDR_BIP_OV, 32'h4000);
		wr(ADDR_CELL_UV, 32'h2000);
		wr(ADDR_BIP_UV, 32'h1000);
		bip = 14'($urandom) & 14'h3FFE | 14'h0002;
		ax = 6'($urandom);
		ctl = 32'h0010;
		wr(ADDR_BIPOLAR, {18'h0, bip});
		wr(ADDR_AUXREF, {26'h0, ax});
		rdc(ADDR_BIPOLAR, {18'h0, bip});
		acq(1'b0);
		// selections changed mid-run must not reach the running acquisition
		wr(ADDR_ACQCTRL, ctl | 32'h1);
		wr(ADDR_BIPOLAR, {18'h0, ~bip});
		wr(ADDR_AUXREF, {26'h0, ~ax});
		rdc(ADDR_LATCHED, {10'h0, ax, 2'b00, bip});
		chk(aux_o, ax);
		chk(ien_o, 1'b0);
		chk(busy_o, 1'b1);
		fin(1'b0);
		bip = ~bip;
		acq(1'b1);
		for (int i = 0; i < 14; i++) begin
			b = bip[i];
			val = i == 0 ? 14'h3FFF : i == 1 ? 14'h2000 : i == 2 ? 14'h0 : 14'($urandom);
			conv(4'(i), val, 1'b0, 1'b0);
			r = {val, 2'b00};
			chk(ov_o, r > (b ? 16'h4000 : 16'hC000));
			chk(uv_o, r < (b ? 16'h1000 : 16'h2000));
			chk(ext_o, !b);
			chk(bsf_o, 1'b0);
			conv(4'(i), val, 1'b1, !b);
			kcmp(4'(i), i[0] ? 10'h3FF : 10'h000);
			chk(skip_o, b);
			chk(cov_o, !b && i[0]);
			chk(cuv_o, !b && !i[0]);
		end
		wr(ADDR_OPTIONS, 32'h1);
		conv(4'h0, 14'h2000, 1'b0, 1'b0);
		chk(ext_o, 1'b1);
		ctl = 32'h0040;
		wr(ADDR_ACQCTRL, ctl);
		bf <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			conv(4'(i), 14'h1000, 1'b0, 1'b0);
			chk(bsf_o, !bip[i]);
		end
		tally_and_finish();
	end
endmodule : test_acquisition_polarity_config
